// ===== rtl/cwg_map.svh
// Purpose: Offsets, field positions, reset values and mode encodings of the waveform generator
// Assumes: AHB-Lite register slave with 32-bit words
// Notes:   Mode encodings keep the forward/reverse pair apart in bit 0 only
`ifndef CWG_MAP_SVH
`define CWG_MAP_SVH
// Register byte offsets
`define CWG_OFS_CTRL0    8'h00
`define CWG_OFS_CTRL1    8'h04
`define CWG_OFS_DBAND    8'h08
`define CWG_OFS_SHUT     8'h0C
`define CWG_OFS_STEER    8'h10
`define CWG_OFS_STATUS   8'h14
// Control 0 fields
`define CWG_C0_MODE_LSB  0
`define CWG_C0_EN_BIT    7
// Control 1 fields: polarity a..d
`define CWG_C1_POL_LSB   0
// Dead band fields
`define CWG_DB_RISE_LSB  0
`define CWG_DB_FALL_LSB  8
`define CWG_DB_REN_BIT   16
`define CWG_DB_FEN_BIT   17
// Shutdown fields
`define CWG_SD_SRC_LSB   0
`define CWG_SD_OVR_LSB   8
`define CWG_SD_REN_BIT   16
`define CWG_SD_SW_BIT    17
// Mode encodings
`define CWG_MODE_STEER_S 3'h0
`define CWG_MODE_STEER_A 3'h1
`define CWG_MODE_FB_FWD  3'h2
`define CWG_MODE_FB_REV  3'h3
`define CWG_MODE_HALF    3'h4
`define CWG_MODE_PUSH    3'h5
// Reset values
`define CWG_RST_WORD     32'h0000_0000
`endif

// ===== rtl/cwg_pkg.sv
// Purpose: Types shared by the waveform generator
// Assumes: Constants live in cwg_map.svh
// Notes:   None
package cwg_pkg;
    typedef struct packed {
        logic [2:0] mode;
        logic       en;
        logic [3:0] pol;
        logic [5:0] rise_cnt;
        logic [5:0] fall_cnt;
        logic       rise_en;
        logic       fall_en;
        logic [3:0] sd_src;
        logic [7:0] sd_ovr;
        logic       sd_restart;
        logic [3:0] steer;
    } cwg_cfg_t;

    typedef struct packed {
        logic        hready;
        logic [31:0] hrdata;
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
    } cwg_bus_t;

    typedef struct packed {
        cwg_cfg_t   cfg;
        cwg_bus_t   bus;
        logic [1:0] in_sync;
        logic       in_prev;
        logic [3:0] sd_meta;
        logic [3:0] sd_sync;
        logic       shut;
        logic       sw_shut;
        logic       a_raw;
        logic       b_raw;
        logic [5:0] dly;
        logic       sync_steer_ld;
        logic [3:0] steer_act;
        logic [3:0] outs;
    } cwg_state_t;
endpackage : cwg_pkg

// ===== rtl/cwg_top.sv
// Purpose: Complementary waveform generator with dead band and auto-shutdown
// Assumes: Pulse input and shutdown sources are asynchronous and are synchronised
// Notes:   Dead band counts in clk_sys cycles; outputs are registered
// Notes on behaviour
// - Two primary waveforms from the selected input
// - Half-bridge: turn-on delayed after other output turns off
// - Three-bit field picks one of six modes
// - One input, four outputs, shutdown always
// - Half-bridge gives true and inverted copies
// - Steering ignored in half-bridge mode
// - Half-bridge and push-pull: outputs c,d copy a,b, own polarity
// - Full-bridge: three static, one modulated
// - Mode bit 0 flips bridge direction live
// - Each output has its own polarity
// - Separate 6-bit rise and fall counts, one shared delay counter
// - Shutdown ends drive promptly on fault
`include "cwg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cwg_top #(
    parameter int NUM_SRC = 4
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    // Pulse input and shutdown sources
    input  wire logic               pulse_in,
    input  wire logic [NUM_SRC-1:0] shutdown_src,
    // Outputs to the bridge drivers
    output logic                    output_a,
    output logic                    output_b,
    output logic                    output_c,
    output logic                    output_d,
    output logic                    shutdown_active
);
    cwg_pkg::cwg_state_t s_q;
    cwg_pkg::cwg_state_t s_d;

    function automatic logic [1:0] ovr_lvl(input logic [1:0] code, input logic pol);
        // 00 inactive, 01 active, 1x drive the output pin low/high fixed
        case (code)
            2'h0:    ovr_lvl = {1'b1, pol};
            2'h1:    ovr_lvl = {1'b1, ~pol};
            2'h2:    ovr_lvl = {1'b1, 1'b0};
            default: ovr_lvl = {1'b1, 1'b1};
        endcase
    endfunction : ovr_lvl

    logic       in_s;
    logic       fault;
    logic       a_tgt;
    logic       b_tgt;
    logic [3:0] raw;
    logic [3:0] st;
    logic [1:0] ov;
    logic [31:0] rd;

    always_comb begin
        s_d = s_q;
        in_s = s_q.in_sync[1];
        fault = |(s_q.sd_sync & s_q.cfg.sd_src) | s_q.sw_shut;
        a_tgt = 1'b0;
        b_tgt = 1'b0;
        raw = 4'h0;
        st = 4'h0;
        ov = 2'h0;
        rd = `CWG_RST_WORD;

        // Bus: data phase follows a one-cycle address phase, zero wait states
        s_d.bus.hready = 1'b1;
        if (s_q.bus.sel && s_q.bus.wr) begin
            case (s_q.bus.addr)
                `CWG_OFS_CTRL0: begin
                    s_d.cfg.mode = hwdata[`CWG_C0_MODE_LSB +: 3];
                    s_d.cfg.en   = hwdata[`CWG_C0_EN_BIT];
                end
                `CWG_OFS_CTRL1: s_d.cfg.pol = hwdata[`CWG_C1_POL_LSB +: 4];
                `CWG_OFS_DBAND: begin
                    s_d.cfg.rise_cnt = hwdata[`CWG_DB_RISE_LSB +: 6];
                    s_d.cfg.fall_cnt = hwdata[`CWG_DB_FALL_LSB +: 6];
                    s_d.cfg.rise_en  = hwdata[`CWG_DB_REN_BIT];
                    s_d.cfg.fall_en  = hwdata[`CWG_DB_FEN_BIT];
                end
                `CWG_OFS_SHUT: begin
                    s_d.cfg.sd_src     = hwdata[`CWG_SD_SRC_LSB +: 4];
                    s_d.cfg.sd_ovr     = hwdata[`CWG_SD_OVR_LSB +: 8];
                    s_d.cfg.sd_restart = hwdata[`CWG_SD_REN_BIT];
                    s_d.sw_shut        = hwdata[`CWG_SD_SW_BIT];
                end
                `CWG_OFS_STEER: s_d.cfg.steer = hwdata[3:0];
                default: ;
            endcase
        end
        s_d.bus.sel  = hsel && hready && htrans[1];
        s_d.bus.wr   = hwrite;
        s_d.bus.addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                `CWG_OFS_CTRL0: rd = {24'h0, s_q.cfg.en, 4'h0, s_q.cfg.mode};
                `CWG_OFS_CTRL1: rd = {28'h0, s_q.cfg.pol};
                `CWG_OFS_DBAND: rd = {14'h0, s_q.cfg.fall_en, s_q.cfg.rise_en,
                                      2'h0, s_q.cfg.fall_cnt, 2'h0, s_q.cfg.rise_cnt};
                `CWG_OFS_SHUT:  rd = {14'h0, s_q.sw_shut, s_q.cfg.sd_restart,
                                      s_q.cfg.sd_ovr, 4'h0, s_q.cfg.sd_src};
                `CWG_OFS_STEER: rd = {28'h0, s_q.cfg.steer};
                `CWG_OFS_STATUS: rd = {26'h0, s_q.a_raw, s_q.b_raw, s_q.outs[3:1],
                                       s_q.shut};
                default:        rd = 32'h0000_0000;
            endcase
        end
        s_d.bus.hrdata = rd;

        // Two-flop synchronisers on pins
        s_d.in_sync = {s_q.in_sync[0], pulse_in};
        // Each source gets its own two flops so the enable mask sees clean levels
        s_d.sd_meta = 4'(shutdown_src);
        s_d.sd_sync = s_q.sd_meta;
        s_d.in_prev = in_s;

        // Shutdown latches on a fault; restart at a rising input once clear
        if (fault) begin
            s_d.shut = 1'b1;
        end else if (s_q.shut && s_q.cfg.sd_restart && in_s && !s_q.in_prev) begin
            s_d.shut = 1'b0;
        end

        // Dead band: a turn-on waits for its count on the shared counter, a turn-off is immediate
        a_tgt = in_s;
        b_tgt = ~in_s;
        if (s_q.cfg.mode == `CWG_MODE_PUSH) begin
            a_tgt = in_s && !s_q.in_prev ? ~s_q.a_raw : s_q.a_raw;
            b_tgt = 1'b0;
        end
        if (!s_q.cfg.en) begin
            s_d.a_raw = 1'b0;
            s_d.b_raw = 1'b0;
            s_d.dly   = 6'h00;
        end else if (s_q.cfg.mode == `CWG_MODE_HALF) begin
            if (!a_tgt) s_d.a_raw = 1'b0;
            if (!b_tgt) s_d.b_raw = 1'b0;
            if (a_tgt && !s_q.a_raw) begin
                if (s_q.b_raw || (s_q.cfg.rise_en && s_q.dly < s_q.cfg.rise_cnt)) begin
                    s_d.dly = s_q.b_raw ? 6'h00 : 6'(s_q.dly + 6'h01);
                end else begin
                    s_d.a_raw = 1'b1;
                    s_d.dly   = 6'h00;
                end
            end else if (b_tgt && !s_q.b_raw) begin
                if (s_q.a_raw || (s_q.cfg.fall_en && s_q.dly < s_q.cfg.fall_cnt)) begin
                    s_d.dly = s_q.a_raw ? 6'h00 : 6'(s_q.dly + 6'h01);
                end else begin
                    s_d.b_raw = 1'b1;
                    s_d.dly   = 6'h00;
                end
            end
        end else if (s_q.cfg.mode == `CWG_MODE_PUSH) begin
            s_d.a_raw = a_tgt;
            s_d.b_raw = in_s && !s_q.in_prev ? s_q.a_raw : s_q.b_raw;
        end else begin
            s_d.a_raw = in_s;
            s_d.b_raw = 1'b0;
        end

        // Synchronous steering takes new settings on a rising input
        if (s_q.cfg.mode == `CWG_MODE_STEER_A || (in_s && !s_q.in_prev)) begin
            s_d.steer_act = s_q.cfg.steer;
        end

        // Output mapping per mode
        case (s_q.cfg.mode)
            `CWG_MODE_HALF: raw = {s_q.b_raw, s_q.a_raw, s_q.b_raw, s_q.a_raw};
            `CWG_MODE_PUSH: raw = {in_s & s_q.b_raw, in_s & s_q.a_raw,
                                   in_s & s_q.b_raw, in_s & s_q.a_raw};
            `CWG_MODE_FB_FWD: raw = {in_s, 1'b0, 1'b0, 1'b1};
            `CWG_MODE_FB_REV: raw = {1'b0, 1'b1, in_s, 1'b0};
            `CWG_MODE_STEER_S, `CWG_MODE_STEER_A: begin
                st  = s_q.steer_act;
                raw = {4{in_s}} & st;
            end
            default: raw = 4'h0;
        endcase
        if (!s_q.cfg.en) raw = 4'h0;
        for (int i = 0; i < 4; i++) begin
            s_d.outs[i] = raw[i] ^ s_q.cfg.pol[i];
            if (s_q.shut || fault) begin
                ov = ovr_lvl(s_q.cfg.sd_ovr[2*i +: 2], s_q.cfg.pol[i]);
                s_d.outs[i] = ov[0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = s_q.bus.hready;
    assign hrdata    = s_q.bus.hrdata;
    assign hresp     = 1'b0;
    assign output_a  = s_q.outs[0];
    assign output_b  = s_q.outs[1];
    assign output_c  = s_q.outs[2];
    assign output_d  = s_q.outs[3];
    assign shutdown_active = s_q.shut;
endmodule : cwg_top
`default_nettype wire

// ===== verification/cwg_bridge_model.sv
// Purpose: Bridge driver stage facing the generator
// Assumes: A high fault line asks for the drive to be cut
// Notes:   Trips only when the bench asks for it
`timescale 1ns/1ps
`default_nettype none
module cwg_bridge_model (
    // Gate drives
    input  wire logic [3:0] gate,
    // Fault request and fault lines
    input  wire logic       fault_req,
    output logic [3:0]      fault
);
    assign fault = {3'h0, fault_req};
endmodule : cwg_bridge_model
`default_nettype wire

// ===== verification/cwg_assertions.sv
// Purpose: Port checks of the waveform generator
// Assumes: Zero-wait bus slave
// Notes:   Shadows control writes to learn mode and polarity
`timescale 1ns/1ps
`default_nettype none
module cwg_assertions (
    // Clock, reset and bus
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    // Drives
    input  wire logic        output_a,
    input  wire logic        output_b,
    input  wire logic        output_c,
    input  wire logic        output_d,
    input  wire logic        shutdown_active
);
    logic       wr_q;
    logic [4:0] ad_q;
    logic [7:0] c0_q;
    logic [3:0] pol_q;
    logic       sw_q;
    logic [3:0] age_q;
    logic [3:0] o;
    logic       ok;
    logic       ha;
    logic       hb;
    assign o  = {output_d, output_c, output_b, output_a};
    assign ha = output_a ^ pol_q[0];
    assign hb = output_b ^ pol_q[1];
    // Outputs trail the settings by several cycles, so wait them out
    assign ok = age_q > 4'h8 && !shutdown_active;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q  <= 1'b0;
            ad_q  <= 5'h00;
            c0_q  <= 8'h00;
            pol_q <= 4'h0;
            sw_q  <= 1'b0;
            age_q <= 4'h0;
        end else begin
            wr_q  <= hsel && hready && htrans[1] && hwrite;
            ad_q  <= haddr[4:0];
            age_q <= wr_q ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
            if (wr_q && ad_q == 5'h00) c0_q <= hwdata[7:0];
            if (wr_q && ad_q == 5'h04) pol_q <= hwdata[3:0];
            if (wr_q && ad_q == 5'h0C) sw_q <= hwdata[17];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    half_gap_a: assert property (ok && c0_q == 8'h84 |-> !(ha && hb))
        else $error("half bridge overlap");
    c_copy_a: assert property (ok && c0_q == 8'h84 |-> (output_c ^ pol_q[2]) == ha)
        else $error("third output differs");
    d_copy_a: assert property (ok && c0_q == 8'h84 |-> (output_d ^ pol_q[3]) == hb)
        else $error("fourth output differs");
    fb_static_a: assert property (ok && c0_q[7] && c0_q[2:1] == 2'h1
        |-> $countones(o ^ $past(o)) <= 1) else $error("bridge moved twice");
    idle_pol_a: assert property (ok && !c0_q[7] |-> o == pol_q)
        else $error("idle level wrong");
    push_gap_a: assert property (ok && c0_q == 8'h85 |-> !(ha && hb))
        else $error("push pull overlap");
    shut_fast_a: assert property ($rose(sw_q) |-> ##[0:4] shutdown_active)
        else $error("shutdown late");
    shut_hold_a: assert property (shutdown_active && sw_q |=> shutdown_active)
        else $error("shutdown dropped");
endmodule : cwg_assertions
bind cwg_top cwg_assertions i_cwg_assertions (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .output_a(output_a), .output_b(output_b), .output_c(output_c), .output_d(output_d),
    .shutdown_active(shutdown_active));
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench of the waveform generator
// Assumes: Zero-wait bus; outputs settle within 12 cycles
// Notes:   External shutdown is tried too
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_sys, rst, hsel, hwrite, pulse_in, fault_req, hrdy, hresp, p, shut;
    logic [1:0]  htrans;
    logic [3:0]  src, pol, o, v;
    logic [31:0] haddr, hwdata, hrdata, rd, x;
    int          miscompares, check_count;
    logic [31:0] msk [5] = '{32'h7, 32'hF, 32'h3_3F3F, 32'h1_FF0F, 32'hF};
    logic [2:0]  md [5] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h5};
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    cwg_top i_cwg_top (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .pulse_in(pulse_in),
        .shutdown_src(src), .output_a(o[0]), .output_b(o[1]), .output_c(o[2]),
        .output_d(o[3]), .shutdown_active(shut));
    cwg_bridge_model i_cwg_bridge_model (.gate(o), .fault_req(fault_req), .fault(src));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (miscompares == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        for (int k = 0; k < 2; k++) begin
            do @(posedge clk_sys); while (hrdy !== 1'b1 && ++n < 40);
            if (k == 0) {htrans, hsel, hwdata} <= {3'h0, d};
        end
        rd = hrdata;
        if (n >= 40) begin
            miscompares++;
            report_and_stop();
        end
    endtask : bus
    task automatic hold(input logic lv);
        pulse_in <= lv;
        repeat (12) @(posedge clk_sys);
    endtask : hold
    initial begin
        {rst, hsel, hwrite, pulse_in, fault_req, htrans, haddr, hwdata} = {5'h10, 66'h0};
        x = $urandom(32'hBC56ECDE);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            check(rd, 32'h0);
            x = $urandom & msk[i];
            bus(1'b1, 8'(i * 4), x);
            bus(1'b0, 8'(i * 4), 32'h0);
            check(rd, x);
            bus(1'b1, 8'(i * 4), 32'h0);
        end
        bus(1'b1, 8'h20, $urandom);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        pol = 4'($urandom);
        bus(1'b1, 8'h04, {28'h0, pol});
        bus(1'b1, 8'h08, 32'h3_0303);
        bus(1'b1, 8'h10, $urandom);
        bus(1'b1, 8'h00, 32'h84);
        repeat (6) begin
            p = 1'($urandom);
            hold(p);
            check(o, {~p, p, ~p, p} ^ pol);
        end
        bus(1'b1, 8'h10, 32'hF);
        for (int j = 0; j < 5; j++) begin
            // Only the bridge direction may change while running
            if (j != 1) bus(1'b1, 8'h00, {29'h0, md[j]});
            bus(1'b1, 8'h00, {29'h0, md[j]} | 32'h80);
            hold(1'b1);
            v = o;
            hold(1'b0);
            if (j < 2) check($countones(v ^ o), 1);
            else if (j < 4) check(v ^ o, 4'hF);
        end
        bus(1'b1, 8'h0C, 32'h2_FF00);
        repeat (6) @(posedge clk_sys);
        check({shut, o}, 5'h1F);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({shut, o}, 5'h0);
        bus(1'b1, 8'h0C, 32'h1_0001);
        bus(1'b1, 8'h00, 32'h84);
        hold(1'b1);
        fault_req <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check({shut, o}, 5'h10);
        fault_req <= 1'b0;
        hold(1'b0);
        hold(1'b1);
        check({shut, o}, 5'h5);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
